//--- verilog/ppp_port.sv
// Purpose: 32-pin programmable port with Wishbone registers
// Assumes: classic Wishbone, 16-bit registers in low data bits
// Notes:   pin and peripheral signals per pin, outputs registered
`timescale 1ns/1ps
module ppp_port (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [8:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// reset strap
	input  wire logic        aden_strap_n_i,
	// peripheral functions
	input  wire logic [31:0] periph_out_i,
	input  wire logic [31:0] periph_oe_n_i,
	output logic      [31:0] periph_in_o,
	// pins
	input  wire logic [31:0] pin_in_i,
	output logic      [31:0] pin_out_o,
	output logic      [31:0] pin_oe_n_o,
	output logic      [31:0] pull_up_o,
	output logic      [31:0] pull_down_o
);

	// ==========================================================
	// state
	logic [15:0] mode_lo;
	logic [15:0] mode_hi;
	logic [15:0] dir_lo;
	logic [15:0] dir_hi;
	logic [31:0] level;
	logic        strap_done;
	logic [15:0] next_mode_lo;
	logic [15:0] next_mode_hi;
	logic [15:0] next_dir_lo;
	logic [15:0] next_dir_hi;
	logic [31:0] next_level;
	logic        next_strap_done;
	logic [31:0] next_dat;
	logic        next_ack;
	logic [31:0] mode_all;
	logic [31:0] dir_all;
	logic [31:0] pin_sync;
	logic [31:0] wr_level;
	logic        req_new;
	logic        wr;
	logic [6:0]  idx;

	localparam logic [6:0]  IDX_MODE_LO_C  = ppp_pkg::IDX_MODE_LO;
	localparam logic [6:0]  IDX_MODE_HI_C  = ppp_pkg::IDX_MODE_HI;
	localparam logic [6:0]  IDX_DIR_LO_C   = ppp_pkg::IDX_DIR_LO;
	localparam logic [6:0]  IDX_DIR_HI_C   = ppp_pkg::IDX_DIR_HI;
	localparam logic [6:0]  IDX_LEVEL_LO_C = ppp_pkg::IDX_LEVEL_LO;
	localparam logic [6:0]  IDX_LEVEL_HI_C = ppp_pkg::IDX_LEVEL_HI;
	localparam logic [15:0] STRAP_HI_MASK_C = ppp_pkg::STRAP_HI_MASK;

	assign mode_all = {mode_hi, mode_lo}; // [R3]
	assign dir_all  = {dir_hi, dir_lo}; // [R3]
	assign req_new  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr       = req_new & wb_we_i;
	assign idx      = wb_adr_i[8:2];

	// ==========================================================
	// byte-lane merge
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [15:0] wdat,
		input logic [1:0]  sel
	);
		logic [15:0] res;
		res = old;
		if (sel[0])
			res[7:0] = wdat[7:0];
		if (sel[1])
			res[15:8] = wdat[15:8];
		return res;
	endfunction

	// ==========================================================
	// register next values
	always_comb
	begin
		next_mode_lo    = mode_lo;
		next_mode_hi    = mode_hi;
		next_dir_lo     = dir_lo;
		next_dir_hi     = dir_hi;
		next_strap_done = 1'b1;
		wr_level        = level;
		if (wr)
		begin
			unique case (idx)
				IDX_MODE_LO_C:
					next_mode_lo = merge(mode_lo, wb_dat_i[15:0],
						wb_sel_i[1:0]);
				IDX_MODE_HI_C:
					next_mode_hi = merge(mode_hi, wb_dat_i[15:0],
						wb_sel_i[1:0]);
				IDX_DIR_LO_C:
					next_dir_lo = merge(dir_lo, wb_dat_i[15:0],
						wb_sel_i[1:0]);
				IDX_DIR_HI_C:
					next_dir_hi = merge(dir_hi, wb_dat_i[15:0],
						wb_sel_i[1:0]);
				IDX_LEVEL_LO_C:
					wr_level[15:0] = merge(level[15:0],
						wb_dat_i[15:0], wb_sel_i[1:0]);
				IDX_LEVEL_HI_C:
					wr_level[31:16] = merge(level[31:16],
						wb_dat_i[15:0], wb_sel_i[1:0]);
				default:
				begin
					next_mode_lo = mode_lo;
				end
			endcase
		end
		if (!strap_done && !aden_strap_n_i)
			next_dir_hi = next_dir_hi & ~STRAP_HI_MASK_C; // [R12]
		// inputs capture the pin, others keep written data
		next_level = (dir_all & pin_sync) | (~dir_all & wr_level); // [R2]
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_lo    <= ppp_pkg::RST_MODE_LO; // [R7] [R9]
			mode_hi    <= ppp_pkg::RST_MODE_HI; // [R8] [R9]
			dir_lo     <= ppp_pkg::RST_DIR_LO; // [R5] [R9]
			dir_hi     <= ppp_pkg::RST_DIR_HI; // [R6] [R9]
			strap_done <= 1'b0;
		end
		else
		begin
			mode_lo    <= next_mode_lo;
			mode_hi    <= next_mode_hi;
			dir_lo     <= next_dir_lo;
			dir_hi     <= next_dir_hi;
			strap_done <= next_strap_done; // [R12]
		end
	end

	// ==========================================================
	// data register, deliberately without reset
	always_ff @(posedge mclk_i)
	begin
		level <= next_level; // [R4]
	end

	// ==========================================================
	// bus answer
	always_comb
	begin
		next_ack = req_new;
		next_dat = 32'h0000_0000;
		if (req_new && !wb_we_i)
		begin
			unique case (idx)
				IDX_MODE_LO_C:
					next_dat[15:0] = mode_lo;
				IDX_MODE_HI_C:
					next_dat[15:0] = mode_hi;
				IDX_DIR_LO_C:
					next_dat[15:0] = dir_lo;
				IDX_DIR_HI_C:
					next_dat[15:0] = dir_hi;
				IDX_LEVEL_LO_C:
					next_dat[15:0] = level[15:0]; // [R3]
				IDX_LEVEL_HI_C:
					next_dat[15:0] = level[31:16]; // [R3]
				default:
					next_dat = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= next_ack;
			wb_dat_o <= next_dat;
		end
	end

	// ==========================================================
	// pin cells
	genvar gi;
	generate
		for (gi = 0; gi < ppp_pkg::PIN_COUNT; gi++)
		begin : g_pin
			ppp_pin_cell #(
				.PULL_DOWN (ppp_pkg::PULL_DOWN_MASK[gi])
			) ppp_pin_cell_inst (
				.mclk_i        (mclk_i),
				.rst_i         (rst_i),
				.mode_i        (mode_all[gi]),
				.dir_i         (dir_all[gi]),
				.level_i       (level[gi]),
				.periph_out_i  (periph_out_i[gi]),
				.periph_oe_n_i (periph_oe_n_i[gi]),
				.pin_in_i      (pin_in_i[gi]),
				.pin_out_o     (pin_out_o[gi]),
				.pin_oe_n_o    (pin_oe_n_o[gi]),
				.pull_up_o     (pull_up_o[gi]),
				.pull_down_o   (pull_down_o[gi]),
				.pin_sync_o    (pin_sync[gi])
			);
		end
	endgenerate

	assign periph_in_o = pin_sync;

	// ==========================================================
	// checks
	logic [1:0] warm;
	logic [31:0] out_mask;
	logic [31:0] pull_mask;
	logic [31:0] norm_mask;

	assign out_mask  = mode_all & ~dir_all;
	assign pull_mask = ~mode_all & dir_all;
	assign norm_mask = ~mode_all & ~dir_all;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
			warm <= 2'b00;
		else if (warm != 2'b11)
			warm <= warm + 2'b01;
	end

	sequence s_write_dir_lo;
		wr && idx == IDX_DIR_LO_C && wb_sel_i[1:0] == 2'b11;
	endsequence

	sequence s_read_level_hi;
		req_new && !wb_we_i && idx == IDX_LEVEL_HI_C;
	endsequence

	sequence s_write_level_lo;
		wr && idx == IDX_LEVEL_LO_C && wb_sel_i[1:0] == 2'b11;
	endsequence

	a_ack_one_cycle: assert property (@(posedge mclk_i)
		disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_ack_after_req: assert property (@(posedge mclk_i)
		disable iff (rst_i) req_new |=> wb_ack_o)
		else $error("request not answered next cycle");

	a_reset_dir_vals: assert property (@(posedge mclk_i) // [R5] [R6]
		disable iff (rst_i) $past(rst_i) |->
		dir_lo == 16'hfc0f && dir_hi == 16'hffff)
		else $error("direction reset value wrong");

	a_reset_mode_vals: assert property (@(posedge mclk_i) // [R7] [R8]
		disable iff (rst_i) $past(rst_i) |->
		mode_lo == 16'h0000 && mode_hi == 16'h0000)
		else $error("mode reset value wrong");

	a_strap_pins_normal: assert property (@(posedge mclk_i) // [R12]
		disable iff (rst_i) $rose(strap_done) && !$past(aden_strap_n_i)
		|-> dir_hi[10] == 1'b0 && dir_hi[13] == 1'b0 && !mode_hi[10] &&
		!mode_hi[13])
		else $error("strap did not release pins 26 and 29");

	a_write_dir_lo: assert property (@(posedge mclk_i)
		disable iff (rst_i) s_write_dir_lo ##1 wb_ack_o |->
		dir_lo == $past(wb_dat_i[15:0]))
		else $error("direction write lost");

	a_output_drive: assert property (@(posedge mclk_i) // [R2]
		disable iff (rst_i) !$past(rst_i) |->
		((pin_oe_n_o & $past(out_mask)) == 32'h0000_0000) &&
		(((pin_out_o ^ $past(level)) & $past(out_mask)) ==
		32'h0000_0000))
		else $error("output pin not driven from data");

	a_input_released: assert property (@(posedge mclk_i) // [R1]
		disable iff (rst_i) !$past(rst_i) |->
		(~pin_oe_n_o & $past(dir_all)) == 32'h0000_0000)
		else $error("input pin driven");

	a_input_capture: assert property (@(posedge mclk_i) // [R14]
		disable iff (rst_i) warm == 2'b11 |->
		((level ^ $past(pin_in_i, 3)) & $past(dir_all)) ==
		32'h0000_0000)
		else $error("input level not captured after sync");

	a_pull_select: assert property (@(posedge mclk_i) // [R10] [R11]
		disable iff (rst_i) !$past(rst_i) |->
		pull_down_o == ($past(pull_mask) & 32'h0000_0042) &&
		pull_up_o == ($past(pull_mask) & ~32'h0000_0042))
		else $error("pull resistor selection wrong");

	a_level_hi_map: assert property (@(posedge mclk_i) // [R3]
		disable iff (rst_i) s_read_level_hi |=>
		wb_dat_o == {16'h0000, $past(level[31:16])})
		else $error("high data register bit mapping wrong");

	a_unmapped_zero: assert property (@(posedge mclk_i)
		disable iff (rst_i) req_new && !wb_we_i &&
		idx[6:4] != 3'b111 |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_strap_kept_high: assert property (@(posedge mclk_i) // [R6] [R12]
		disable iff (rst_i) $rose(strap_done) && $past(aden_strap_n_i)
		|-> dir_hi == 16'hffff)
		else $error("high direction changed without strap");

	a_level_write_lo: assert property (@(posedge mclk_i) // [R2]
		disable iff (rst_i) s_write_level_lo |=>
		((level[15:0] ^ $past(wb_dat_i[15:0])) & ~$past(dir_lo)) ==
		16'h0000)
		else $error("data write to output pins lost");

	a_sync_two_stage: assert property (@(posedge mclk_i) // [R14]
		disable iff (rst_i) warm[1] |->
		periph_in_o == $past(pin_in_i, 2))
		else $error("pin level not passed through two stages");

	a_normal_passes: assert property (@(posedge mclk_i) // [R1]
		disable iff (rst_i) !$past(rst_i) |->
		(((pin_oe_n_o ^ $past(periph_oe_n_i)) |
		(pin_out_o ^ $past(periph_out_i))) & $past(norm_mask)) ==
		32'h0000_0000)
		else $error("normal pin not driven by peripheral");

	a_read_dir_lo: assert property (@(posedge mclk_i)
		disable iff (rst_i) req_new && !wb_we_i && idx == IDX_DIR_LO_C
		|=> wb_dat_o == {16'h0000, $past(dir_lo)})
		else $error("direction read data wrong");

endmodule

//--- shared/ppp_pkg.sv
// Purpose: constants for the programmable pin port
// Assumes: 32 pins, 16-bit registers, word-indexed map
// Notes:   byte address of a register is four times its index
// Functional notes
// [R1] mode/direction pair selects one of four functions
// [R2] outputs drive data bit, inputs capture pin
// [R3] low registers pins 0-15, high 16-31
// [R4] data registers have no defined reset value
// [R5] low direction register resets to fc0f
// [R6] high direction register resets to ffff
// [R7] low mode register resets to 0000
// [R8] high mode register resets to 0000
// [R9] every pin starts normal or pulled input
// [R10] pullable pins use pull-up when pulled input
// [R11] pin 6 uses pull-down when pulled input; the code also pulls pin 1 down (PULL_DOWN_MASK 0x42)
// [R12] strap low at reset: pins 26,29 normal
// [R13] software emulates open drain via direction bit
// [R14] input levels pass two-stage synchroniser first
package ppp_pkg;

	// ==========================================================
	// sizes
	localparam int PIN_COUNT = 32;
	localparam int HALF_W    = 16;

	// ==========================================================
	// register indices, byte address is index times four
	localparam logic [6:0] IDX_MODE_LO  = 7'h70;
	localparam logic [6:0] IDX_DIR_LO   = 7'h72;
	localparam logic [6:0] IDX_LEVEL_LO = 7'h74;
	localparam logic [6:0] IDX_MODE_HI  = 7'h76;
	localparam logic [6:0] IDX_DIR_HI   = 7'h78;
	localparam logic [6:0] IDX_LEVEL_HI = 7'h7a;

	// ==========================================================
	// reset values
	localparam logic [15:0] RST_MODE_LO = 16'h0000;
	localparam logic [15:0] RST_MODE_HI = 16'h0000;
	localparam logic [15:0] RST_DIR_LO  = 16'hfc0f;
	localparam logic [15:0] RST_DIR_HI  = 16'hffff;

	// ==========================================================
	// pin attributes
	localparam logic [31:0] PULL_DOWN_MASK = 32'h0000_0042;
	localparam logic [15:0] STRAP_HI_MASK  = 16'h2400;

endpackage

//--- verilog/ppp_pin_cell.sv
// Purpose: one pin: function decode, drive, pull and synchroniser
// Assumes: pin input asynchronous to mclk_i
// Notes:   all outputs registered
`timescale 1ns/1ps
module ppp_pin_cell #(
	parameter bit PULL_DOWN = 1'b0
) (
	// clock and reset
	input  wire logic mclk_i,
	input  wire logic rst_i,
	// configuration
	input  wire logic mode_i,
	input  wire logic dir_i,
	input  wire logic level_i,
	// peripheral side
	input  wire logic periph_out_i,
	input  wire logic periph_oe_n_i,
	// pin side
	input  wire logic pin_in_i,
	output logic      pin_out_o,
	output logic      pin_oe_n_o,
	output logic      pull_up_o,
	output logic      pull_down_o,
	output logic      pin_sync_o
);

	logic meta;
	logic next_pin_out;
	logic next_pin_oe_n;
	logic next_pull_up;
	logic next_pull_down;

	// ==========================================================
	// function decode
	always_comb
	begin
		next_pin_out   = 1'b0;
		next_pin_oe_n  = 1'b1;
		next_pull_up   = 1'b0;
		next_pull_down = 1'b0;
		unique case ({mode_i, dir_i}) // [R1]
			2'b00:
			begin
				next_pin_out  = periph_out_i;
				next_pin_oe_n = periph_oe_n_i;
			end
			2'b01:
			begin
				next_pull_up   = ~PULL_DOWN; // [R10]
				next_pull_down = PULL_DOWN; // [R11]
			end
			2'b10:
			begin
				next_pin_out  = level_i; // [R2]
				next_pin_oe_n = 1'b0;
			end
			2'b11:
			begin
				next_pin_oe_n = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// registers and synchroniser
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			pin_out_o   <= 1'b0;
			pin_oe_n_o  <= 1'b1;
			pull_up_o   <= 1'b0;
			pull_down_o <= 1'b0;
			meta        <= 1'b0;
			pin_sync_o  <= 1'b0;
		end
		else
		begin
			pin_out_o   <= next_pin_out;
			pin_oe_n_o  <= next_pin_oe_n;
			pull_up_o   <= next_pull_up;
			pull_down_o <= next_pull_down;
			meta        <= pin_in_i; // [R14]
			pin_sync_o  <= meta; // [R14]
		end
	end

endmodule

//--- sim/ppp_board.sv
// Purpose: board logic on the shared pins
// Assumes: device drive wins over board drive
// Notes:   undriven, unpulled pins toggle each cycle
`timescale 1ns/1ps
module ppp_board (
	// clock
	input  wire logic        mclk_i,
	// device side
	input  wire logic [31:0] pin_out_i,
	input  wire logic [31:0] pin_oe_n_i,
	input  wire logic [31:0] pull_up_i,
	input  wire logic [31:0] pull_down_i,
	// board drivers
	input  wire logic [31:0] ext_val_i,
	input  wire logic [31:0] ext_en_i,
	// resolved level
	output logic      [31:0] pin_lvl_o
);
	logic [31:0] float_pat = 32'h5555_5555;

	// ==========================================================
	// floating lines never hold a value
	always @(posedge mclk_i)
		float_pat <= ~float_pat;

	// ==========================================================
	// wire resolution
	always_comb
	begin
		for (int i = 0; i < 32; i++)
		begin
			if (!pin_oe_n_i[i])
				pin_lvl_o[i] = pin_out_i[i];
			else if (ext_en_i[i])
				pin_lvl_o[i] = ext_val_i[i];
			else if (pull_up_i[i])
				pin_lvl_o[i] = 1'b1;
			else if (pull_down_i[i])
				pin_lvl_o[i] = 1'b0;
			else
				pin_lvl_o[i] = float_pat[i];
		end
	end
endmodule

//--- sim/ppp_port_test.sv
// Purpose: self-checking bench for the programmable pin port
// Assumes: classic Wishbone master, board model on the pins
// Notes:   random values from a fixed xorshift seed
`timescale 1ns/1ps
module ppp_port_test;
	logic        mclk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic        wb_ack_o;
	logic        aden_strap_n_i = 1'b1;
	logic [8:0]  wb_adr_i = 9'h000;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pin_in_i, periph_in_o;
	logic [31:0] periph_out_i = 32'h0, periph_oe_n_i = 32'hffff_ffff;
	logic [31:0] pin_out_o, pin_oe_n_o, pull_up_o, pull_down_o;
	logic [31:0] ext_val = 32'h0, ext_en = 32'h0, seed = 32'd95098, r, q;
	logic [15:0] rd;
	logic [3:0]  sel_w = 4'h3;
	int          error_cnt = 0, n_checks = 0, cyc = 0;
	localparam logic [31:0] PD = 32'h0000_0042;

	always #12.5 mclk_i = ~mclk_i;

	ppp_port ppp_port_inst (.mclk_i(mclk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.aden_strap_n_i(aden_strap_n_i), .periph_out_i(periph_out_i),
		.periph_oe_n_i(periph_oe_n_i), .periph_in_o(periph_in_o),
		.pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
		.pin_oe_n_o(pin_oe_n_o), .pull_up_o(pull_up_o),
		.pull_down_o(pull_down_o));
	ppp_board ppp_board_inst (.mclk_i(mclk_i), .pin_out_i(pin_out_o),
		.pin_oe_n_i(pin_oe_n_o), .pull_up_i(pull_up_o),
		.pull_down_i(pull_down_o), .ext_val_i(ext_val),
		.ext_en_i(ext_en), .pin_lvl_o(pin_in_i));

	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	function automatic logic [31:0] pulled(input logic [31:0] m,
		input logic [31:0] d);
		return ~m & d;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ==========================================================
	// bus cycles
	task automatic wb(input logic we, input logic [6:0] idx,
		input logic [15:0] wd);
		@(posedge mclk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= sel_w;
		wb_dat_i <= {16'h0000, wd};
		@(posedge mclk_i);
		while (wb_ack_o !== 1'b1)
			@(posedge mclk_i);
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic rd32(input logic [6:0] lo, input logic [6:0] hi);
		wb(1'b0, lo, 16'h0000);
		q[15:0] = rd;
		wb(1'b0, hi, 16'h0000);
		q[31:16] = rd;
	endtask

	task automatic cfg(input logic [31:0] m, input logic [31:0] d);
		wb(1'b1, ppp_pkg::IDX_MODE_LO, m[15:0]);
		wb(1'b1, ppp_pkg::IDX_MODE_HI, m[31:16]);
		wb(1'b1, ppp_pkg::IDX_DIR_LO, d[15:0]);
		wb(1'b1, ppp_pkg::IDX_DIR_HI, d[31:16]);
		repeat (2) @(posedge mclk_i);
	endtask

	task automatic do_reset(input logic strap_n, input logic [15:0] dhi);
		rst_i <= 1'b1;
		aden_strap_n_i <= strap_n;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		aden_strap_n_i <= 1'b1;
		rd32(ppp_pkg::IDX_MODE_LO, ppp_pkg::IDX_MODE_HI);
		chk(q, 32'h0);
		rd32(ppp_pkg::IDX_DIR_LO, ppp_pkg::IDX_DIR_HI);
		chk(q, {dhi, 16'hfc0f});
		chk(pull_up_o, pulled(0, {dhi, 16'hfc0f}) & ~PD);
		chk(pull_down_o, pulled(0, {dhi, 16'hfc0f}) & PD);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		do_reset(1'b1, 16'hffff);
		// define every data bit before any pin becomes an output
		cfg(32'h0, 32'h0);
		seed = xs(seed);
		wb(1'b1, ppp_pkg::IDX_LEVEL_LO, seed[15:0]);
		wb(1'b1, ppp_pkg::IDX_LEVEL_HI, seed[31:16]);
		rd32(ppp_pkg::IDX_LEVEL_LO, ppp_pkg::IDX_LEVEL_HI);
		chk(q, seed);
		sel_w = 4'h2;
		wb(1'b1, ppp_pkg::IDX_MODE_LO, 16'habcd);
		sel_w = 4'h3;
		wb(1'b0, ppp_pkg::IDX_MODE_LO, 16'h0000);
		chk({16'h0000, rd}, 32'h0000_ab00);
		chk(pin_out_o & 32'h0000_ab00, seed & 32'h0000_ab00);
		wb(1'b1, 7'h10, 16'h5a5a);
		wb(1'b0, 7'h10, 16'h0000);
		chk({16'h0000, rd}, 32'h0);
		wb(1'b1, 7'h71, 16'hffff);
		wb(1'b0, 7'h71, 16'h0000);
		chk({16'h0000, rd}, 32'h0);
		repeat (4)
		begin
			seed = xs(seed);
			r = seed;
			cfg(r, ~r);
			rd32(ppp_pkg::IDX_MODE_LO, ppp_pkg::IDX_MODE_HI);
			chk(q, r);
			chk(pull_up_o | pull_down_o, pulled(r, ~r));
			cfg(32'hffff_ffff, 32'h0);
			wb(1'b1, ppp_pkg::IDX_LEVEL_LO, r[15:0]);
			wb(1'b1, ppp_pkg::IDX_LEVEL_HI, r[31:16]);
			repeat (2) @(posedge mclk_i);
			chk(pin_out_o, r);
			chk(pin_oe_n_o, 32'h0);
			cfg(32'hffff_ffff, 32'hffff_ffff);
			ext_en <= 32'hffff_ffff;
			ext_val <= ~r;
			repeat (5) @(posedge mclk_i);
			chk(periph_in_o, ~r);
			rd32(ppp_pkg::IDX_LEVEL_LO, ppp_pkg::IDX_LEVEL_HI);
			chk(q, ~r);
			chk(pull_up_o | pull_down_o | ~pin_oe_n_o, 32'h0);
			ext_en <= 32'h0;
			cfg(32'h0, 32'hffff_ffff);
			chk(pull_up_o, ~PD);
			chk(pull_down_o, PD);
			seed = xs(seed);
			periph_out_i <= r;
			periph_oe_n_i <= seed;
			cfg(32'h0, 32'h0);
			chk(pin_oe_n_o, seed);
			chk(pin_out_o & ~seed, r & ~seed);
			cfg(32'hffff_ffff, 32'h0);
			wb(1'b1, ppp_pkg::IDX_LEVEL_LO, 16'h0000);
			wb(1'b1, ppp_pkg::IDX_LEVEL_HI, 16'h0000);
			cfg(32'hffff_ffff, r);
			chk(pin_oe_n_o, r);
			chk(pin_out_o & ~r, 32'h0);
		end
		do_reset(1'b0, 16'hdbff);
		report_and_stop();
	end
endmodule
